// [design/wdp_pkg.sv]
// Purpose: Shared constants for the prescaled down-counting watchdog.
// Assumes: 32-bit AXI4-Lite register bus, byte addresses on word boundaries.
// Notes: Offsets of all registers are local choices.
package wdp_pkg;
	// Register byte offsets
	localparam logic [7:0] WDP_OFF_CTRL = 8'h00;
	localparam logic [7:0] WDP_OFF_LOAD = 8'h04;
	localparam logic [7:0] WDP_OFF_FEED1 = 8'h08;
	localparam logic [7:0] WDP_OFF_FEED2 = 8'h0c;
	localparam logic [7:0] WDP_OFF_IEN = 8'h10;
	localparam logic [7:0] WDP_OFF_IPRI = 8'h14;
	localparam logic [7:0] WDP_OFF_POWER_CONTROL = 8'h18;
	localparam logic [7:0] WDP_OFF_STAT = 8'h1c;
	// Control, interrupt and power control field positions
	localparam int WDP_CTRL_MODE = 0;
	localparam int WDP_CTRL_TOF = 1;
	localparam int WDP_CTRL_RUN = 2;
	localparam int WDP_CTRL_TAP_LO = 5;
	localparam int WDP_IEN_WD = 6;
	localparam int WDP_IEN_ALL = 7;
	localparam int WDP_IPRI_WD = 6;
	localparam int WDP_POWER_CONTROL_SLEEP = 0;
	localparam int WDP_POWER_CONTROL_PD = 1;
	localparam int WDP_POWER_CONTROL_SSLEEP = 6;
	// Reset and key values
	localparam logic [7:0] WDP_LOAD_RST = 8'hff;
	localparam logic [2:0] WDP_TAP_RST = 3'h7;
	localparam logic [7:0] WDP_FEED_KEY1 = 8'ha5;
	localparam logic [7:0] WDP_FEED_KEY2 = 8'h5a;
	// Prescaler geometry and interrupt vector
	localparam int WDP_DIV_FIRST = 12;
	localparam int WDP_STAGES = 13;
	localparam int WDP_TAP_BASE = 6;
	localparam logic [7:0] WDP_WD_VECTOR = 8'h33;
	// AXI responses
	localparam logic [1:0] WDP_RESP_OK = 2'h0;
	localparam logic [1:0] WDP_RESP_SLVERR = 2'h2;
endpackage : wdp_pkg

// [design/wdp_tick_if.sv]
// Purpose: Carrier between the watchdog core and its prescaler.
// Assumes: One clock domain.
// Notes: Clear and enable come from the core; the tick goes back.
`timescale 1ns/1ps
interface wdp_tick_if;
	logic enable; // Prescaler clocks only while running
	logic clear; // Restart prescaler on autoload
	logic [2:0] tap; // Tap selection
	logic tick; // One-cycle pulse at selected tap rollover
	modport core (output enable, output clear, output tap, input tick);
	modport pre (input enable, input clear, input tap, output tick);
endinterface : wdp_tick_if

// [design/wdp_prescaler.sv]
// Purpose: Divide-by-12 then 13-stage binary counter with selectable tap.
// Assumes: Clock is the oscillator-derived system clock.
// Notes: Tick pulses when the selected stage and all below roll over.
`timescale 1ns/1ps
module wdp_prescaler
	import wdp_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	wdp_tick_if.pre tk
);
	logic [3:0] div_r; // Fixed divide-by-12 stage
	logic [WDP_STAGES-1:0] cnt_r; // Ripple-equivalent binary stages
	wire div_wrap = (div_r == 4'(WDP_DIV_FIRST - 1));
	wire [3:0] tap_idx = 4'(WDP_TAP_BASE - 1) + {1'b0, tk.tap};
	wire [WDP_STAGES-1:0] low_mask = WDP_STAGES'((14'h1 << (tap_idx + 4'h1)) - 14'h1);
	// Tick when all stages through the tap are ones and the next step comes
	assign tk.tick = tk.enable && div_wrap && ((cnt_r & low_mask) == low_mask);

	// Divider and counter; frozen when not enabled to save power
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			div_r <= 4'h0;
			cnt_r <= '0;
		end else if (tk.clear) begin
			div_r <= 4'h0;
			cnt_r <= '0;
		end else if (tk.enable) begin
			div_r <= div_wrap ? 4'h0 : div_r + 4'h1;
			cnt_r <= div_wrap ? cnt_r + 1'b1 : cnt_r;
		end
	end
endmodule : wdp_prescaler

// [design/wdp_watchdog.sv]
// Purpose: Watchdog timer with prescaler, autoload down counter and feed.
// Assumes: Registers reached over AXI4-Lite; one write and read at a time.
// Notes: Chip reset and interrupt leave as registered outputs.
//
// Operation
// - Oscillator divided by 12, then 13 stages
// - Prescaler tap selectable stage 6 to 13
// - Main counter decrements on each prescaler tick
// - Tick at zero underflows and autoloads
// - Counter and autoload value are 8 bits
// - Every autoload also clears the prescaler
// - Minimum timeout is 12 times 64 clocks
// - Maximum timeout is minimum times 128 times 256
// - Timer interrupt lowest priority, vector 33h
// - Interrupt needs own enable and global enable
// - Priority bit selects interrupt level
// - Running watchdog blocks power-down entry
// - Power-down wins over idle together
// - Stopped timer has its clocks gated
// - Underflow: interrupt in timer, reset otherwise
// - Feed is A5 then 5A consecutively
// - Reset restores defaults and autoloads
// - Flag clears on vector entry or write
`timescale 1ns/1ps
module wdp_watchdog
	import wdp_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	input wire logic [7:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [7:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	input wire logic I_IRQ_ACK,
	output logic O_IRQ_REQ,
	output logic O_IRQ_HIGH,
	output logic [7:0] O_IRQ_VECTOR,
	output logic O_CHIP_RESET,
	output logic O_POWER_DOWN,
	output logic O_CPU_SLEEP
);
	wdp_tick_if tk ();

	// Software-visible state
	logic watchdog_mode_select_r; // 1 selects reset-on-underflow
	logic watchdog_timeout_flag_r; // Set on every underflow
	logic watchdog_run_control_r; // Timer on/off
	logic [2:0] tap_sel_r; // Prescaler tap, top bit is tap_select_high
	logic [7:0] autoload_value_r; // Reload value
	logic [7:0] count_r; // Main down counter
	logic [7:0] ien_r; // Interrupt enable register copy
	logic [7:0] ipri_r; // Interrupt priority register copy
	logic [7:0] power_control_r; // Power control register copy
	logic feed_armed_r; // First feed key seen on the previous write
	logic reload_pend_r; // Autoload requested after reset
	logic [7:0] count_nxt;

	// Bus state
	// One write at a time: address and data are held until both are present
	logic aw_hold_r;
	logic [7:0] aw_addr_r;
	logic w_hold_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;

	// Write channel acceptance; each address and data may come first
	wire aw_take = I_AWVALID && O_AWREADY;
	wire w_take = I_WVALID && O_WREADY;
	wire wr_go = aw_hold_r && w_hold_r;
	// Next hold and response state; the readies are registered from it so
	// that they leave a flop yet behave exactly as the inverse of the holds and of the pending response
	wire aw_hold_nxt = wr_go ? 1'b0 : (aw_take ? 1'b1 : aw_hold_r);
	wire w_hold_nxt = wr_go ? 1'b0 : (w_take ? 1'b1 : w_hold_r);
	wire bvalid_nxt = wr_go ? 1'b1 : ((O_BVALID && I_BREADY) ? 1'b0 : O_BVALID);
	wire lane0 = w_strb_r[0];
	wire [7:0] wbyte = w_data_r[7:0];
	wire hit_ctrl = aw_addr_r == WDP_OFF_CTRL;
	wire hit_load = aw_addr_r == WDP_OFF_LOAD;
	wire hit_feed1 = aw_addr_r == WDP_OFF_FEED1;
	wire hit_feed2 = aw_addr_r == WDP_OFF_FEED2;
	wire hit_ien = aw_addr_r == WDP_OFF_IEN;
	wire hit_ipri = aw_addr_r == WDP_OFF_IPRI;
	wire hit_power_control = aw_addr_r == WDP_OFF_POWER_CONTROL;
	wire wr_known = hit_ctrl | hit_load | hit_feed1 | hit_feed2 | hit_ien | hit_ipri | hit_power_control;
	wire wr_en = wr_go && lane0;

	// Feed sequence: key 1 then key 2 on the very next register write
	wire feed1_ok = wr_en && hit_feed1 && wbyte == WDP_FEED_KEY1;
	wire feed_done = wr_en && hit_feed2 && wbyte == WDP_FEED_KEY2 && feed_armed_r;
	// A lone second key looks like a runaway program, so it resets as well
	// Any other write after the first key, or a bad second key, is a feed fault
	wire feed_fault = wr_go && (feed_armed_r ? !feed_done : (hit_feed2 && lane0));

	// Counter control; the prescaler runs only while the counter may count,
	// so a stopped timer keeps both its count and its prescaler phase
	wire running = watchdog_run_control_r || watchdog_mode_select_r;
	wire underflow = tk.tick && count_r == 8'h00;
	wire reload = underflow || feed_done || reload_pend_r;
	assign tk.enable = running;
	assign tk.clear = reload;
	assign tk.tap = tap_sel_r;

	// Next count: autoload, decrement or hold
	always_comb begin
		count_nxt = count_r;
		if (reload) begin
			count_nxt = autoload_value_r;
		end else if (tk.tick) begin
			count_nxt = count_r - 8'h01;
		end
	end

	wire wd_reset_evt = (underflow && watchdog_mode_select_r) || feed_fault;
	wire ctrl_wr = wr_en && hit_ctrl;
	wire tof_clr = ctrl_wr && !wbyte[WDP_CTRL_TOF];
	wire irq_flag_clr = I_IRQ_ACK || tof_clr;
	// Power-down refused while running, and wins over idle
	wire power_control_wr = wr_en && hit_power_control;
	wire pd_req = power_control_wr && wbyte[WDP_POWER_CONTROL_PD] && !running;
	wire sl_req = power_control_wr && wbyte[WDP_POWER_CONTROL_SLEEP] && !wbyte[WDP_POWER_CONTROL_PD];

	// Prescaler keeps the divide chain apart from the register logic
	wdp_prescaler u_pre (
		.i_clk(I_CLK),
		.i_rst(I_SYS_RST),
		.tk(tk.pre)
	);

	// Watchdog counter and status
	// After reset the autoload is one edge late, which also clears the prescaler
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			count_r <= 8'h00;
			reload_pend_r <= 1'b1;
			watchdog_timeout_flag_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			reload_pend_r <= 1'b0;
			// Set wins over a same-cycle clear
			if (underflow) begin
				watchdog_timeout_flag_r <= 1'b1;
			end else if (irq_flag_clr) begin
				watchdog_timeout_flag_r <= 1'b0;
			end
		end
	end

	// Configuration registers; mode bit may only be set by software
	// Enable holds all eight bits, priority only the low seven; only the watchdog bits act here
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			watchdog_mode_select_r <= 1'b0;
			watchdog_run_control_r <= 1'b0;
			tap_sel_r <= WDP_TAP_RST;
			autoload_value_r <= WDP_LOAD_RST;
			ien_r <= 8'h00;
			ipri_r <= 8'h00;
		end else begin
			if (ctrl_wr) begin
				watchdog_mode_select_r <= watchdog_mode_select_r | wbyte[WDP_CTRL_MODE];
				watchdog_run_control_r <= wbyte[WDP_CTRL_RUN];
				tap_sel_r <= wbyte[WDP_CTRL_TAP_LO +: 3];
			end
			if (wr_en && hit_load) begin
				autoload_value_r <= wbyte;
			end
			if (wr_en && hit_ien) begin
				ien_r <= wbyte;
			end
			if (wr_en && hit_ipri) begin
				ipri_r <= wbyte & 8'h7f;
			end
		end
	end

	// Feed tracker and power control
	// Any completed write moves the feed tracker, so keys must be back to back
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			feed_armed_r <= 1'b0;
			power_control_r <= 8'h00;
		end else begin
			if (wr_go) begin
				feed_armed_r <= feed1_ok && !feed_armed_r;
			end
			if (wr_en && hit_power_control) begin
				power_control_r <= {wbyte[7:2], pd_req, sl_req};
			end else if (I_IRQ_ACK) begin
				power_control_r[WDP_POWER_CONTROL_SLEEP] <= 1'b0; // Interrupt wakes the processor
			end
		end
	end

	// Registered outputs toward the processor core
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			O_IRQ_REQ <= 1'b0;
			O_IRQ_HIGH <= 1'b0;
			O_IRQ_VECTOR <= WDP_WD_VECTOR;
			O_CHIP_RESET <= 1'b0;
			O_POWER_DOWN <= 1'b0;
			O_CPU_SLEEP <= 1'b0;
		end else begin
			// Request only in timer mode, gated by own and global enables
			O_IRQ_REQ <= watchdog_timeout_flag_r && !watchdog_mode_select_r
				&& !irq_flag_clr && ien_r[WDP_IEN_WD] && ien_r[WDP_IEN_ALL];
			O_IRQ_HIGH <= ipri_r[WDP_IPRI_WD];
			O_IRQ_VECTOR <= WDP_WD_VECTOR;
			O_CHIP_RESET <= wd_reset_evt;
			// A power control write overrides the held copy in its own cycle,
			// so power-down and idle are never granted together
			O_POWER_DOWN <= power_control_wr ? pd_req : (power_control_r[WDP_POWER_CONTROL_PD] && !running);
			O_CPU_SLEEP <= power_control_wr ? sl_req : power_control_r[WDP_POWER_CONTROL_SLEEP];
		end
	end

	// Write path: latch address and data, respond once both are held
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			aw_hold_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_hold_r <= 1'b0;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
			O_BVALID <= 1'b0;
			O_BRESP <= WDP_RESP_OK;
			O_AWREADY <= 1'b1;
			O_WREADY <= 1'b1;
		end else begin
			// Ready again only once the response has been taken
			O_AWREADY <= !aw_hold_nxt && !bvalid_nxt;
			O_WREADY <= !w_hold_nxt && !bvalid_nxt;
			if (aw_take) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= I_AWADDR;
			end
			if (w_take) begin
				w_hold_r <= 1'b1;
				w_data_r <= I_WDATA;
				w_strb_r <= I_WSTRB;
			end
			if (wr_go) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				O_BVALID <= 1'b1;
				O_BRESP <= wr_known ? WDP_RESP_OK : WDP_RESP_SLVERR;
			end else if (O_BVALID && I_BREADY) begin
				O_BVALID <= 1'b0;
			end
		end
	end

	// Read decode
	// Decode straight from the request address; the answer is latched on take
	wire [7:0] ctrl_rd = {tap_sel_r, 2'b00, watchdog_run_control_r,
		watchdog_timeout_flag_r, watchdog_mode_select_r};
	wire rd_known = I_ARADDR == WDP_OFF_CTRL || I_ARADDR == WDP_OFF_LOAD
		|| I_ARADDR == WDP_OFF_IEN || I_ARADDR == WDP_OFF_IPRI
		|| I_ARADDR == WDP_OFF_POWER_CONTROL || I_ARADDR == WDP_OFF_STAT
		|| I_ARADDR == WDP_OFF_FEED1 || I_ARADDR == WDP_OFF_FEED2;
	wire [7:0] rd_byte = (I_ARADDR == WDP_OFF_CTRL) ? ctrl_rd
		: (I_ARADDR == WDP_OFF_LOAD) ? autoload_value_r
		: (I_ARADDR == WDP_OFF_IEN) ? ien_r
		: (I_ARADDR == WDP_OFF_IPRI) ? ipri_r
		: (I_ARADDR == WDP_OFF_POWER_CONTROL) ? power_control_r
		: (I_ARADDR == WDP_OFF_STAT) ? count_r : 8'h00;
	// Read address taken and next valid; feed registers read back as zero
	wire rd_take = I_ARVALID && O_ARREADY;
	wire rvalid_nxt = rd_take ? 1'b1 : ((O_RVALID && I_RREADY) ? 1'b0 : O_RVALID);

	// Read path: one-cycle answer, held until the master takes it
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			O_ARREADY <= 1'b1;
			O_RVALID <= 1'b0;
			O_RDATA <= 32'h0;
			O_RRESP <= WDP_RESP_OK;
		end else begin
			// Ready is the registered inverse of the next valid
			O_ARREADY <= !rvalid_nxt;
			O_RVALID <= rvalid_nxt;
			if (rd_take) begin
				O_RDATA <= {24'h0, rd_byte};
				O_RRESP <= rd_known ? WDP_RESP_OK : WDP_RESP_SLVERR;
			end
		end
	end
endmodule : wdp_watchdog

// [verification/wdp_watchdog_checker.sv]
// Purpose: Port-level checks of the prescaled watchdog.
// Assumes: Single clock, reset active high.
// Notes: Internal counts are judged by the bench.
`timescale 1ns/1ps
module wdp_watchdog_checker
	import wdp_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	input wire logic I_AWVALID,
	input wire logic O_AWREADY,
	input wire logic I_WVALID,
	input wire logic O_WREADY,
	input wire logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [1:0] O_BRESP,
	input wire logic I_ARVALID,
	input wire logic O_ARREADY,
	input wire logic O_RVALID,
	input wire logic I_IRQ_ACK,
	input wire logic O_IRQ_REQ,
	input wire logic [7:0] O_IRQ_VECTOR,
	input wire logic O_CHIP_RESET,
	input wire logic O_POWER_DOWN,
	input wire logic O_CPU_SLEEP
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);
	// Vector never moves
	property p_vec; O_IRQ_VECTOR == WDP_WD_VECTOR; endproperty
	a_vec: assert property (p_vec) else $error("vector wrong");
	// Both write channels taken: answer one edge after both are held
	property p_bv; I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |=> ##1 O_BVALID; endproperty
	a_bv: assert property (p_bv) else $error("bvalid late");
	// Response held until taken
	property p_bst; O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP); endproperty
	a_bst: assert property (p_bst) else $error("bresp dropped");
	// No new write while answer pending
	property p_wrdy; O_BVALID |-> !O_AWREADY && !O_WREADY; endproperty
	a_wrdy: assert property (p_wrdy) else $error("ready during bvalid");
	property p_rv; I_ARVALID && O_ARREADY |=> O_RVALID; endproperty
	a_rv: assert property (p_rv) else $error("rvalid late");
	property p_arr; O_ARREADY == !O_RVALID; endproperty
	a_arr: assert property (p_arr) else $error("arready wrong");
	// Chip reset is a single-cycle pulse
	property p_crp; O_CHIP_RESET |=> !O_CHIP_RESET; endproperty
	a_crp: assert property (p_crp) else $error("reset pulse long");
	// Power-down beats idle
	property p_pd; !(O_POWER_DOWN && O_CPU_SLEEP); endproperty
	a_pd: assert property (p_pd) else $error("pd and idle");
	// Vector entry clears the request at the next edge
	property p_ack; I_IRQ_ACK |=> !O_IRQ_REQ; endproperty
	a_ack: assert property (p_ack) else $error("irq not cleared");
	c_rst: cover property (O_CHIP_RESET);
	c_irq: cover property (O_IRQ_REQ);
	c_pd: cover property (O_POWER_DOWN);
endmodule : wdp_watchdog_checker
bind wdp_watchdog wdp_watchdog_checker u_chk (
	.I_CLK(I_CLK),
	.I_SYS_RST(I_SYS_RST),
	.I_AWVALID(I_AWVALID),
	.O_AWREADY(O_AWREADY),
	.I_WVALID(I_WVALID),
	.O_WREADY(O_WREADY),
	.O_BVALID(O_BVALID),
	.I_BREADY(I_BREADY),
	.O_BRESP(O_BRESP),
	.I_ARVALID(I_ARVALID),
	.O_ARREADY(O_ARREADY),
	.O_RVALID(O_RVALID),
	.I_IRQ_ACK(I_IRQ_ACK),
	.O_IRQ_REQ(O_IRQ_REQ),
	.O_IRQ_VECTOR(O_IRQ_VECTOR),
	.O_CHIP_RESET(O_CHIP_RESET),
	.O_POWER_DOWN(O_POWER_DOWN),
	.O_CPU_SLEEP(O_CPU_SLEEP)
);

// [verification/wdp_watchdog_tb.sv]
// Purpose: Self-checking bench of the prescaled watchdog.
// Assumes: Bench drives bus and vector acknowledge itself.
// Notes: Periods measured between interrupt rises.
`timescale 1ns/1ps
module wdp_watchdog_tb;
	import wdp_pkg::*;
	logic I_CLK = 1'h0, I_SYS_RST = 1'h1, I_AWVALID = 1'h0, I_WVALID = 1'h0;
	logic I_BREADY = 1'h0, I_ARVALID = 1'h0, I_RREADY = 1'h0, I_IRQ_ACK = 1'h0;
	logic [7:0] I_AWADDR = 8'h00, I_ARADDR = 8'h00;
	logic [31:0] I_WDATA = 32'h0;
	logic [3:0] I_WSTRB = 4'hf;
	logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_IRQ_REQ, O_IRQ_HIGH;
	logic O_CHIP_RESET, O_POWER_DOWN, O_CPU_SLEEP;
	logic [1:0] O_BRESP, O_RRESP, br_d;
	logic [31:0] O_RDATA, rd_d;
	logic [7:0] O_IRQ_VECTOR;
	int mismatches = 0, total_checks = 0, cyc = 0, nrst = 0, n;
	wdp_watchdog uut (
		.I_CLK(I_CLK),
		.I_SYS_RST(I_SYS_RST),
		.I_AWADDR(I_AWADDR),
		.I_AWVALID(I_AWVALID),
		.O_AWREADY(O_AWREADY),
		.I_WDATA(I_WDATA),
		.I_WSTRB(I_WSTRB),
		.I_WVALID(I_WVALID),
		.O_WREADY(O_WREADY),
		.O_BRESP(O_BRESP),
		.O_BVALID(O_BVALID),
		.I_BREADY(I_BREADY),
		.I_ARADDR(I_ARADDR),
		.I_ARVALID(I_ARVALID),
		.O_ARREADY(O_ARREADY),
		.O_RDATA(O_RDATA),
		.O_RRESP(O_RRESP),
		.O_RVALID(O_RVALID),
		.I_RREADY(I_RREADY),
		.I_IRQ_ACK(I_IRQ_ACK),
		.O_IRQ_REQ(O_IRQ_REQ),
		.O_IRQ_HIGH(O_IRQ_HIGH),
		.O_IRQ_VECTOR(O_IRQ_VECTOR),
		.O_CHIP_RESET(O_CHIP_RESET),
		.O_POWER_DOWN(O_POWER_DOWN),
		.O_CPU_SLEEP(O_CPU_SLEEP)
	);
	// 40 MHz clock
	always #12.5 I_CLK = ~I_CLK;
	// Cycle and reset-pulse counters
	always @(posedge I_CLK) begin
		cyc <= cyc + 1;
		if (O_CHIP_RESET === 1'h1) nrst <= nrst + 1;
	end
	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_sim
	task ck(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : ck
	function automatic logic sg(input int s);
		case (s)
			0: return O_AWREADY && O_WREADY;
			1: return O_BVALID;
			2: return O_ARREADY;
			3: return O_RVALID;
			default: return O_IRQ_REQ;
		endcase
	endfunction : sg
	// Bounded wait on a settled level, sampled at falling edges
	task wt(input int s, input int lim);
		int i;
		@(negedge I_CLK);
		for (i = 0; i < lim && sg(s) !== 1'h1; i++) @(negedge I_CLK);
		if (sg(s) !== 1'h1) begin
			mismatches++;
			$display("Error wait %0d expired", s);
			end_sim();
		end
	endtask : wt
	// Write: bready raised late so the slave must hold its answer
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge I_CLK);
		I_AWADDR <= a;
		I_WDATA <= {24'h0, d};
		I_AWVALID <= 1'h1;
		I_WVALID <= 1'h1;
		wt(0, 50);
		@(posedge I_CLK);
		I_AWVALID <= 1'h0;
		I_WVALID <= 1'h0;
		wt(1, 50);
		br_d = O_BRESP;
		@(posedge I_CLK);
		I_BREADY <= 1'h1;
		@(posedge I_CLK);
		I_BREADY <= 1'h0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge I_CLK);
		I_ARADDR <= a;
		I_ARVALID <= 1'h1;
		I_RREADY <= 1'h1;
		wt(2, 50);
		@(posedge I_CLK);
		I_ARVALID <= 1'h0;
		wt(3, 50);
		rd_d = O_RDATA;
		@(posedge I_CLK);
		I_RREADY <= 1'h0;
	endtask : rd
	task feed;
		wr(WDP_OFF_FEED1, WDP_FEED_KEY1);
		wr(WDP_OFF_FEED2, WDP_FEED_KEY2);
	endtask : feed
	task ack;
		@(posedge I_CLK);
		I_IRQ_ACK <= 1'h1;
		@(posedge I_CLK);
		I_IRQ_ACK <= 1'h0;
		repeat (3) @(negedge I_CLK);
		ck("irq_after_ack", 32'h0, O_IRQ_REQ);
	endtask : ack
	task t_rst;
		rd(WDP_OFF_CTRL);
		ck("ctrl_rst", 32'he0, rd_d);
		rd(WDP_OFF_LOAD);
		ck("load_rst", 32'hff, rd_d);
		rd(WDP_OFF_STAT);
		ck("count_rst", 32'hff, rd_d);
		ck("vector", 32'h33, O_IRQ_VECTOR);
		rd(8'h20);
		ck("unmapped", WDP_RESP_SLVERR, O_RRESP);
		wr(8'h20, 8'h00);
		ck("unmapped_wr", WDP_RESP_SLVERR, br_d);
	endtask : t_rst
	// Exact period between underflows for one tap and autoload
	task t_per(input logic [7:0] c, input logic [7:0] l, input int e);
		int t1;
		wr(WDP_OFF_LOAD, l);
		wr(WDP_OFF_CTRL, c);
		feed();
		ack();
		wt(4, 8000);
		t1 = cyc;
		ack();
		wt(4, 8000);
		ck("period", e, cyc - t1);
	endtask : t_per
	task t_pd;
		wr(WDP_OFF_IEN, 8'h40);
		ack();
		repeat (3500) @(negedge I_CLK);
		ck("irq_masked", 32'h0, O_IRQ_REQ);
		wr(WDP_OFF_POWER_CONTROL, 8'h02);
		repeat (2) @(negedge I_CLK);
		ck("pd_refused", 32'h0, O_POWER_DOWN);
		wr(WDP_OFF_CTRL, 8'h00);
		wr(WDP_OFF_POWER_CONTROL, 8'h03);
		repeat (2) @(negedge I_CLK);
		ck("pd_won", 32'h1, O_POWER_DOWN);
		ck("idle_lost", 32'h0, O_CPU_SLEEP);
		wr(WDP_OFF_POWER_CONTROL, 8'h01);
		repeat (2) @(negedge I_CLK);
		ck("idle_set", 32'h1, O_CPU_SLEEP);
		ck("pd_left", 32'h0, O_POWER_DOWN);
		ack();
		ck("idle_woken", 32'h0, O_CPU_SLEEP);
		wr(WDP_OFF_POWER_CONTROL, 8'h00);
	endtask : t_pd
	task t_bad;
		n = nrst;
		wr(WDP_OFF_FEED2, WDP_FEED_KEY2);
		repeat (3) @(negedge I_CLK);
		ck("lone_key2", n + 1, nrst);
		wr(WDP_OFF_FEED1, WDP_FEED_KEY1);
		wr(WDP_OFF_CTRL, 8'h00);
		repeat (3) @(negedge I_CLK);
		ck("broken_feed", n + 2, nrst);
	endtask : t_bad
	// Watchdog mode: underflow resets the chip, no interrupt
	task t_wd;
		wr(WDP_OFF_IEN, 8'hc0);
		wr(WDP_OFF_LOAD, 8'h00);
		feed();
		wr(WDP_OFF_CTRL, 8'h05);
		n = nrst;
		feed();
		repeat (400) @(negedge I_CLK);
		feed();
		repeat (500) @(negedge I_CLK);
		ck("fed_in_time", n, nrst);
		repeat (300) @(negedge I_CLK);
		ck("wd_reset", n + 1, nrst);
		ck("wd_no_irq", 32'h0, O_IRQ_REQ);
		rd(WDP_OFF_CTRL);
		ck("timeout_flag", 32'h1, rd_d[1]);
	endtask : t_wd
	// Main sequence
	initial begin
		repeat (16) @(posedge I_CLK);
		I_SYS_RST <= 1'h0;
		t_rst();
		wr(WDP_OFF_IEN, 8'hc0);
		wr(WDP_OFF_IPRI, 8'h40);
		t_per(8'h04, 8'h00, 768);
		ck("irq_level", 32'h1, O_IRQ_HIGH);
		t_per(8'h24, 8'h01, 3072);
		t_pd();
		t_bad();
		t_wd();
		@(posedge I_CLK);
		I_SYS_RST <= 1'h1;
		repeat (4) @(posedge I_CLK);
		I_SYS_RST <= 1'h0;
		t_rst();
		end_sim();
	end
endmodule : wdp_watchdog_tb
